// ---- hdl/smsl_pkg.sv ----
/*
 * constants for the synthesizer mode, seed and filter register bank.
 * assumes a 32-bit classic wishbone bus with word addressing by index*4.
 */
// What this block does
// - oscillator subsystem enabled only by modes bit 0 and chip-enable input.
// - bit 4 enables primary LO buffer, bit 5 secondary LO buffer.
// - bit 6 enables the external oscillator input path, reset clear.
// - pre-lock mute bit 7 mutes both LO buffers until lock.
// - bit 8 set drives only primary negative pin, else differential.
// - bit 9 set drives only secondary negative pin, else differential.
// - bit 11 routes charge pump to output a (0) or b (1).
// - modes register resets to 0x1ab.
// - bias bits 20:19 reset zero; bits 18:0 reserved reset 0x54c1.
// - in exact mode seed sets phase as 2pi times seed over 2^24.
// - outside exact mode with auto seeding, seed sets start phase.
// - outside exact mode with auto seeding off, seed reloads as start phase per change.
// - filter band codes 0..15 select corners, reset code 15.
// - filter register is write-only and reads back as zero.
// - in exact mode with phase sync set, chip-enable rising edge triggers phase resync.
package smsl_pkg;
    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] SMSL_IDX_MODES = 8'h17;
    localparam logic [7:0] SMSL_IDX_BIAS = 8'h18;
    localparam logic [7:0] SMSL_IDX_CAL = 8'h19;
    localparam logic [7:0] SMSL_IDX_SEED = 8'h1a;
    localparam logic [7:0] SMSL_IDX_LPF = 8'h21;
    localparam logic [7:0] SMSL_IDX_CTRL = 8'h30;
    localparam logic [7:0] SMSL_IDX_STAT = 8'h31;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [23:0] SMSL_MODES_RST = 24'h00_01ab;
    localparam logic [23:0] SMSL_BIAS_RST = 24'h00_54c1;
    localparam logic [23:0] SMSL_CAL_RST = 24'h00_0aaa;
    localparam logic [23:0] SMSL_SEED_RST = 24'hb2_9d0b;
    localparam logic [3:0] SMSL_LPF_RST = 4'hf;
    localparam logic [7:0] SMSL_LPF_KEY = 8'hc1;
    // ------------------------------------------------------------
    // modes field positions
    // ------------------------------------------------------------
    localparam int SMSL_M_MASTER = 0;
    localparam int SMSL_M_OSC = 1;
    localparam int SMSL_M_EXTBUF = 2;
    localparam int SMSL_M_LOOPBUF = 3;
    localparam int SMSL_M_LO1 = 4;
    localparam int SMSL_M_LO2 = 5;
    localparam int SMSL_M_EXTIN = 6;
    localparam int SMSL_M_MUTE = 7;
    localparam int SMSL_M_SE1 = 8;
    localparam int SMSL_M_SE2 = 9;
    localparam int SMSL_M_PUMP = 11;
    localparam int SMSL_B_BIAS_LO = 19;
    // control register (own): exact mode, auto seed, phase sync
    localparam int SMSL_C_EXACT = 0;
    localparam int SMSL_C_AUTOSEED = 1;
    localparam int SMSL_C_PSYNC = 2;
    localparam logic [2:0] SMSL_CTRL_RST = 3'h4;
    typedef enum logic [1:0] {
        SMSL_IDLE = 2'b00,
        SMSL_ACK = 2'b01
    } smsl_bus_t;
endpackage : smsl_pkg

// ---- hdl/smsl_pin_drv.sv ----
/*
 * one LO output pair: enable, mute and single-ended selection.
 * assumes the lock and mute levels are synchronous to clk_i.
 */
`timescale 1ns/1ns
module smsl_pin_drv
    import smsl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic osc_on_i,
    input wire logic buf_en_i,
    input wire logic mute_en_i,
    input wire logic locked_i,
    input wire logic single_i,
    output logic pos_o,
    output logic neg_o
);
    typedef struct packed {
        logic pos;
        logic neg;
    } smsl_drv_t;
    smsl_drv_t st_r;
    smsl_drv_t st_nxt;
    logic live;

    // buffer live only when enabled and not held by the pre-lock mute
    always_comb begin
        live = osc_on_i & buf_en_i & ~(mute_en_i & ~locked_i);
        st_nxt.neg = live;
        st_nxt.pos = live & ~single_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pos_o = st_r.pos;
    assign neg_o = st_r.neg;

    a_mute_holds: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (mute_en_i && !locked_i) |=> !neg_o && !pos_o
    ) else $error("pin driven while muted before lock");
    a_single_pos: assert property (
        @(posedge clk_i) disable iff (rst_i)
        single_i |=> !pos_o
    ) else $error("positive pin driven in single-ended mode");
endmodule : smsl_pin_drv

// ---- hdl/smsl_phase.sv ----
/*
 * start-phase loader: chooses when the seed becomes the output phase.
 * assumes chip-enable and frequency-change strobes are synchronous.
 */
`timescale 1ns/1ns
module smsl_phase
    import smsl_pkg::*;
#(
    parameter int W = 24
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] seed_i,
    input wire logic exact_i,
    input wire logic autoseed_i,
    input wire logic psync_i,
    input wire logic chip_en_i,
    input wire logic freq_chg_i,
    input wire logic start_i,
    output logic [W-1:0] phase_o,
    output logic load_o
);
    typedef struct packed {
        logic [W-1:0] phase;
        logic load;
        logic ce;
    } smsl_ph_t;
    smsl_ph_t st_r;
    smsl_ph_t st_nxt;
    logic trig;

    // pick the load event by mode
    always_comb begin
        st_nxt = st_r;
        st_nxt.ce = chip_en_i;
        trig = 1'b0;
        if (exact_i) begin
            trig = start_i | (psync_i & chip_en_i & ~st_r.ce);
        end else if (autoseed_i) begin
            trig = start_i;
        end else begin
            trig = start_i | freq_chg_i;
        end
        st_nxt.load = trig;
        if (trig) begin
            st_nxt.phase = seed_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign phase_o = st_r.phase;
    assign load_o = st_r.load;

    a_reload_chg: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!exact_i && !autoseed_i && freq_chg_i) |=>
        load_o && phase_o == $past(seed_i)
    ) else $error("seed not reloaded after frequency change");
    a_sync_trig: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (exact_i && psync_i && chip_en_i && !$past(chip_en_i)) |=> load_o
    ) else $error("phase sync trigger missed");
    c_sync: cover property (@(posedge clk_i) exact_i && psync_i && load_o);
endmodule : smsl_phase

// ---- hdl/smsl_regs.sv ----
/*
 * synthesizer mode, bias, calibration, seed and filter register bank.
 * assumes a classic wishbone master, 32-bit data, one clock.
 */
`timescale 1ns/1ns
module smsl_regs
    import smsl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // device side
    input wire logic chip_en_i,
    input wire logic pll_locked_i,
    input wire logic freq_chg_i,
    output logic osc_on_o,
    output logic osc_core_on_o,
    output logic ext_buf_on_o,
    output logic loop_buf_on_o,
    output logic ext_in_on_o,
    output logic primary_lo_pos_pin_o,
    output logic primary_lo_neg_pin_o,
    output logic secondary_lo_pos_pin_o,
    output logic secondary_lo_neg_pin_o,
    output logic pump_output_a_o,
    output logic pump_output_b_o,
    output logic [1:0] ext_bias_o,
    output logic [23:0] cal_o,
    output logic [3:0] lpf_band_o,
    output logic [23:0] phase_o,
    output logic phase_load_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        smsl_bus_t bus;
        logic ack;
        logic err;
        logic [31:0] rdat;
        logic [23:0] modes;
        logic [23:0] bias;
        logic [23:0] cal;
        logic [23:0] seed;
        logic [3:0] lpf;
        logic [2:0] ctrl;
        logic start;
        logic osc;
    } smsl_st_t;
    smsl_st_t st_r;
    smsl_st_t st_nxt;
    logic [7:0] idx;
    logic req;
    logic hit;
    logic [31:0] wmask;

    // word index from the byte address; the low two bits are ignored,
    // so a misaligned access lands on the word that holds it
    assign idx = adr_i[9:2];
    // a request stands while cycle and strobe are both high
    assign req = cyc_i & stb_i;

    // byte-lane write mask from sel
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{sel_i[b]}};
        end
    end

    // decode valid register indices
    always_comb begin
        case (idx)
            SMSL_IDX_MODES, SMSL_IDX_BIAS, SMSL_IDX_CAL, SMSL_IDX_SEED,
            SMSL_IDX_LPF, SMSL_IDX_CTRL, SMSL_IDX_STAT: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // bus and register next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.err = 1'b0;
        // oscillator on needs master bit and chip enable
        st_nxt.osc = st_r.modes[SMSL_M_MASTER] & chip_en_i;
        // start pulse when the subsystem turns on;
        // it loads the seed as start phase in every mode
        st_nxt.start = st_nxt.osc & ~st_r.osc;
        case (st_r.bus)
            SMSL_IDLE: begin
                if (req) begin
                    st_nxt.bus = SMSL_ACK;
                    st_nxt.ack = hit;
                    st_nxt.err = ~hit;
                    st_nxt.rdat = 32'h0000_0000;
                    if (!we_i) begin
                        case (idx)
                            SMSL_IDX_MODES: st_nxt.rdat = {8'h00, st_r.modes};
                            SMSL_IDX_BIAS: st_nxt.rdat = {8'h00, st_r.bias};
                            SMSL_IDX_CAL: st_nxt.rdat = {8'h00, st_r.cal};
                            SMSL_IDX_SEED: st_nxt.rdat = {8'h00, st_r.seed};
                            SMSL_IDX_LPF: st_nxt.rdat = 32'h0000_0000;
                            SMSL_IDX_CTRL: st_nxt.rdat = {29'h0, st_r.ctrl};
                            SMSL_IDX_STAT: st_nxt.rdat =
                                {30'h0, pll_locked_i, st_r.osc};
                            default: st_nxt.rdat = 32'h0000_0000;
                        endcase
                    end else begin
                        case (idx)
                            SMSL_IDX_MODES: st_nxt.modes =
                                (st_r.modes & ~wmask[23:0])
                                | (dat_i[23:0] & wmask[23:0]);
                            SMSL_IDX_BIAS: st_nxt.bias =
                                (st_r.bias & ~wmask[23:0])
                                | (dat_i[23:0] & wmask[23:0]);
                            SMSL_IDX_CAL: st_nxt.cal =
                                (st_r.cal & ~wmask[23:0])
                                | (dat_i[23:0] & wmask[23:0]);
                            SMSL_IDX_SEED: st_nxt.seed =
                                (st_r.seed & ~wmask[23:0])
                                | (dat_i[23:0] & wmask[23:0]);
                            SMSL_IDX_LPF: begin
                                // only the band code is kept; the key
                                // byte in the upper lane is not stored
                                if (sel_i[0]) begin
                                    st_nxt.lpf = dat_i[3:0];
                                end
                            end
                            SMSL_IDX_CTRL: begin
                                if (sel_i[0]) begin
                                    st_nxt.ctrl = dat_i[2:0];
                                end
                            end
                            default: st_nxt.rdat = 32'h0000_0000;
                        endcase
                    end
                end
            end
            SMSL_ACK: begin
                // the master still holds its request while ack stands;
                // this state keeps it from being taken twice, and the
                // bus is idle again one cycle later
                st_nxt.bus = SMSL_IDLE;
            end
            default: st_nxt.bus = SMSL_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.bus <= SMSL_IDLE;
            st_r.ack <= 1'b0;
            st_r.err <= 1'b0;
            st_r.rdat <= 32'h0000_0000;
            st_r.modes <= SMSL_MODES_RST;
            st_r.bias <= SMSL_BIAS_RST;
            st_r.cal <= SMSL_CAL_RST;
            st_r.seed <= SMSL_SEED_RST;
            st_r.lpf <= SMSL_LPF_RST;
            st_r.ctrl <= SMSL_CTRL_RST;
            st_r.start <= 1'b0;
            st_r.osc <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // bus answer straight from the state registers
    assign ack_o = st_r.ack;
    assign err_o = st_r.err;
    assign dat_o = st_r.rdat;
    assign osc_on_o = st_r.osc;
    // every enable below is gated by the running subsystem
    assign osc_core_on_o = st_r.osc & st_r.modes[SMSL_M_OSC];
    assign ext_buf_on_o = st_r.osc & st_r.modes[SMSL_M_EXTBUF];
    assign loop_buf_on_o = st_r.osc & st_r.modes[SMSL_M_LOOPBUF];
    assign ext_in_on_o = st_r.osc & st_r.modes[SMSL_M_EXTIN];
    assign pump_output_a_o = st_r.osc & ~st_r.modes[SMSL_M_PUMP];
    assign pump_output_b_o = st_r.osc & st_r.modes[SMSL_M_PUMP];
    assign ext_bias_o = st_r.bias[SMSL_B_BIAS_LO +: 2];
    assign cal_o = st_r.cal;
    assign lpf_band_o = st_r.lpf;

    // primary LO pair
    smsl_pin_drv u_lo1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .osc_on_i(st_r.osc),
        .buf_en_i(st_r.modes[SMSL_M_LO1]),
        .mute_en_i(st_r.modes[SMSL_M_MUTE]),
        .locked_i(pll_locked_i),
        .single_i(st_r.modes[SMSL_M_SE1]),
        .pos_o(primary_lo_pos_pin_o),
        .neg_o(primary_lo_neg_pin_o)
    );

    // secondary LO pair
    smsl_pin_drv u_lo2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .osc_on_i(st_r.osc),
        .buf_en_i(st_r.modes[SMSL_M_LO2]),
        .mute_en_i(st_r.modes[SMSL_M_MUTE]),
        .locked_i(pll_locked_i),
        .single_i(st_r.modes[SMSL_M_SE2]),
        .pos_o(secondary_lo_pos_pin_o),
        .neg_o(secondary_lo_neg_pin_o)
    );

    // seed to phase loader
    smsl_phase #(
        .W(24)
    ) u_phase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .seed_i(st_r.seed),
        .exact_i(st_r.ctrl[SMSL_C_EXACT]),
        .autoseed_i(st_r.ctrl[SMSL_C_AUTOSEED]),
        .psync_i(st_r.ctrl[SMSL_C_PSYNC]),
        .chip_en_i(chip_en_i),
        .freq_chg_i(freq_chg_i),
        .start_i(st_r.start),
        .phase_o(phase_o),
        .load_o(phase_load_o)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // oscillator follows master bit and chip enable, one cycle late
    a_master_ce: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        !chip_en_i |=> !osc_on_o
    ) else $error("oscillator on without chip enable");
    a_osc_up: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        (st_r.modes[SMSL_M_MASTER] && chip_en_i) |=> osc_on_o
    ) else $error("oscillator off with master bit and chip enable");

    // charge pump drives one output at most
    a_pump_route: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        !(pump_output_a_o && pump_output_b_o)
    ) else $error("charge pump on both outputs");

    // a disabled output buffer leaves both of its pins off
    a_lo1_off: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        !st_r.modes[SMSL_M_LO1]
        |=> !primary_lo_pos_pin_o && !primary_lo_neg_pin_o
    ) else $error("primary pins on with buffer disabled");
    a_lo2_off: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        !st_r.modes[SMSL_M_LO2]
        |=> !secondary_lo_pos_pin_o && !secondary_lo_neg_pin_o
    ) else $error("secondary pins on with buffer disabled");

    // external input path only with its mode bit
    a_ext_in: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        !st_r.modes[SMSL_M_EXTIN] |-> !ext_in_on_o
    ) else $error("external input on while disabled");

    // every turn-on loads the seed as start phase
    a_start_load: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        $rose(osc_on_o) |=> phase_load_o
    ) else $error("no phase load after turn-on");

    // filter band reads as zero and moves only on its own write
    a_lpf_noread: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        (req && !we_i && idx == SMSL_IDX_LPF && st_r.bus == SMSL_IDLE)
        |=> ack_o && dat_o == 32'h0000_0000
    ) else $error("filter register returned data");
    a_lpf_hold: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        !(req && we_i && idx == SMSL_IDX_LPF) |=> $stable(lpf_band_o)
    ) else $error("filter band changed without a write");

    // values after reset, seen on the edge after each reset edge
    a_modes_rst: assert property (
        @(posedge clk_i)
        $past(rst_i) |-> st_r.modes == 24'h00_01ab
    ) else $error("modes reset value wrong");
    a_lpf_rst: assert property (
        @(posedge clk_i)
        $past(rst_i) |-> lpf_band_o == 4'hf && ext_bias_o == 2'b00
    ) else $error("filter or bias reset wrong");
    a_other_rst: assert property (
        @(posedge clk_i)
        $past(rst_i) |-> st_r.bias == SMSL_BIAS_RST
        && cal_o == SMSL_CAL_RST && st_r.seed == SMSL_SEED_RST
    ) else $error("bias, calibration or seed reset wrong");

    // bus answers: one pulse per request, ack or err but never both
    a_ack_one: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        ack_o |=> !ack_o
    ) else $error("ack held two cycles");
    a_one_answer: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        !(ack_o && err_o)
    ) else $error("ack and err together");
    a_unmapped_refused: assert property (
        @(posedge clk_i)
        disable iff (rst_i)
        (req && !hit && st_r.bus == SMSL_IDLE) |=> err_o && !ack_o
    ) else $error("unmapped index not refused");

    // main scenarios
    c_write: cover property (@(posedge clk_i) ack_o && we_i);
    c_read: cover property (@(posedge clk_i) ack_o && !we_i);
    c_unmapped: cover property (@(posedge clk_i) err_o);
    c_lpf_write: cover property (@(posedge clk_i)
        req && we_i && idx == SMSL_IDX_LPF && ack_o);
endmodule : smsl_regs

// ---- testbench/smsl_regs_test.sv ----
/*
 * self-checking bench for the synthesizer mode, seed and filter registers.
 * assumes smsl_pkg is compiled first; the bench drives every dut port.
 */
`timescale 1ns/1ns
module smsl_regs_test
    import smsl_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o;
    logic [9:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic chip_en_i, pll_locked_i, freq_chg_i;
    logic osc_on_o, osc_core_on_o, ext_buf_on_o, loop_buf_on_o, ext_in_on_o;
    logic ppos, pneg, spos, sneg, pump_a, pump_b, phase_load_o;
    logic [1:0] ext_bias_o;
    logic [23:0] cal_o, phase_o;
    logic [3:0] lpf_band_o;
    int mismatches, cmp_count;

    smsl_regs dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .chip_en_i(chip_en_i), .pll_locked_i(pll_locked_i),
        .freq_chg_i(freq_chg_i), .osc_on_o(osc_on_o),
        .osc_core_on_o(osc_core_on_o), .ext_buf_on_o(ext_buf_on_o),
        .loop_buf_on_o(loop_buf_on_o), .ext_in_on_o(ext_in_on_o),
        .primary_lo_pos_pin_o(ppos), .primary_lo_neg_pin_o(pneg),
        .secondary_lo_pos_pin_o(spos), .secondary_lo_neg_pin_o(sneg),
        .pump_output_a_o(pump_a), .pump_output_b_o(pump_b),
        .ext_bias_o(ext_bias_o), .cal_o(cal_o), .lpf_band_o(lpf_band_o),
        .phase_o(phase_o), .phase_load_o(phase_load_o)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    // one classic cycle; holds the request until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] idx,
            input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'hf;
        adr_i <= {idx, 2'b00};
        dat_i <= wd;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            report_and_stop();
        end
        rd = dat_o;
        er = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] r;
        logic e;
        wb(1'b1, idx, wd, r, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        wb(1'b0, idx, 32'h0000_0000, r, e);
        check(r, exp);
    endtask : rd_chk

    // bounded wait for a phase load pulse
    task automatic wait_load(output logic got);
        got = 1'b0;
        repeat (10) begin
            @(posedge clk_i);
            if (phase_load_o === 1'b1) got = 1'b1;
        end
    endtask : wait_load

    task automatic settle;
        repeat (3) @(posedge clk_i);
    endtask : settle

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rd_chk(SMSL_IDX_MODES, 32'h0000_01ab);
        rd_chk(SMSL_IDX_BIAS, 32'h0000_54c1);
        rd_chk(SMSL_IDX_CAL, 32'h0000_0aaa);
        rd_chk(SMSL_IDX_SEED, 32'h00b2_9d0b);
        rd_chk(SMSL_IDX_CTRL, 32'h0000_0004);
        check({28'h000_0000, lpf_band_o}, 32'h0000_000f);
        wb(1'b0, 8'h20, 32'h0000_0000, r, e);
        check({31'h0, e}, 32'h0000_0001);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_enable;
        settle();
        check({31'h0, osc_on_o}, 32'h0000_0000);
        chip_en_i <= 1'b1;
        settle();
        check({28'h0, osc_on_o, osc_core_on_o, loop_buf_on_o, ext_buf_on_o},
            32'h0000_000e);
        check({30'h0, pump_a, pump_b}, 32'h0000_0002);
        check({28'h0, ppos, pneg, spos, sneg}, 32'h0000_0000);
        pll_locked_i <= 1'b1;
        settle();
        check({28'h0, ppos, pneg, spos, sneg}, 32'h0000_0003);
        rd_chk(SMSL_IDX_STAT, 32'h0000_0003);
        $display("test enable and mute done");
    endtask : t_enable

    task automatic t_modes;
        wr(SMSL_IDX_MODES, 32'h0000_0bff);
        rd_chk(SMSL_IDX_MODES, 32'h0000_0bff);
        settle();
        check({28'h0, ppos, pneg, spos, sneg}, 32'h0000_0005);
        check({30'h0, pump_a, pump_b}, 32'h0000_0001);
        check({30'h0, ext_in_on_o, ext_buf_on_o}, 32'h0000_0003);
        pll_locked_i <= 1'b0;
        settle();
        check({28'h0, ppos, pneg, spos, sneg}, 32'h0000_0000);
        pll_locked_i <= 1'b1;
        wr(SMSL_IDX_MODES, 32'h0000_0bfe);
        settle();
        check({30'h0, osc_on_o, pneg}, 32'h0000_0000);
        wr(SMSL_IDX_MODES, 32'h0000_01ab);
        $display("test mode bits done");
    endtask : t_modes

    task automatic t_bias_cal_filter;
        wr(SMSL_IDX_BIAS, 32'h0018_54c1);
        check({30'h0, ext_bias_o}, 32'h0000_0003);
        rd_chk(SMSL_IDX_BIAS, 32'h0018_54c1);
        wr(SMSL_IDX_CAL, 32'h0000_0ab2);
        check({8'h00, cal_o}, 32'h0000_0ab2);
        for (int c = 0; c < 16; c++) begin
            wr(SMSL_IDX_LPF, 32'h00c1_0000 | 32'(c));
            check({28'h0, lpf_band_o}, 32'(c));
        end
        rd_chk(SMSL_IDX_LPF, 32'h0000_0000);
        $display("test bias, calibration and filter done");
    endtask : t_bias_cal_filter

    task automatic t_phase;
        logic got;
        wr(SMSL_IDX_SEED, 32'h0012_3456);
        wr(SMSL_IDX_CTRL, 32'h0000_0005);
        chip_en_i <= 1'b0;
        settle();
        chip_en_i <= 1'b1;
        // sync loads on the first edge, turn-on only one edge later
        repeat (2) @(posedge clk_i);
        check({31'h0, phase_load_o}, 32'h0000_0001);
        wait_load(got);
        check({31'h0, got}, 32'h0000_0001);
        check({8'h00, phase_o}, 32'h0012_3456);
        wr(SMSL_IDX_CTRL, 32'h0000_0002);
        wr(SMSL_IDX_SEED, 32'h00ab_cdef);
        freq_chg_i <= 1'b1;
        @(posedge clk_i);
        freq_chg_i <= 1'b0;
        wait_load(got);
        check({31'h0, got}, 32'h0000_0000);
        chip_en_i <= 1'b0;
        settle();
        chip_en_i <= 1'b1;
        // no sync outside exact mode: nothing loads on the first edge
        repeat (2) @(posedge clk_i);
        check({31'h0, phase_load_o}, 32'h0000_0000);
        wait_load(got);
        check({8'h00, phase_o}, 32'h00ab_cdef);
        wr(SMSL_IDX_CTRL, 32'h0000_0000);
        wr(SMSL_IDX_SEED, 32'h0000_0777);
        freq_chg_i <= 1'b1;
        @(posedge clk_i);
        freq_chg_i <= 1'b0;
        wait_load(got);
        check({31'h0, got}, 32'h0000_0001);
        check({8'h00, phase_o}, 32'h0000_0777);
        $display("test phase loading done");
    endtask : t_phase

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        mismatches = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, chip_en_i, pll_locked_i, freq_chg_i} = 6'h00;
        adr_i = 10'h000;
        sel_i = 4'hf;
        dat_i = 32'h0000_0000;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_enable();
        t_modes();
        t_bias_cal_filter();
        t_phase();
        report_and_stop();
    end
endmodule : smsl_regs_test
